// ### rtl/iosm_top.sv
// io switch matrix: holds the host-selected configuration and drives the pins
//
// Behaviour
// RULE1: all pins released while reset is held
// RULE2: pins zero to four fixed spi slave
// RULE3: pin five drives audio out only in C
// RULE4: pin six audio in A-C, uart rx D
// RULE5: pin seven audio out A,B; uart tx C,D
// RULE6: pin eight uart tx A; receive enable B-D
// RULE7: pin nine uart rx A; amplifier enable B-D
// RULE8: pins ten, eleven audio clock/select A-C
// RULE9: host command after boot picks configuration
// RULE10: pins five-eleven released until command arrives
// RULE11: front-end enables only reach switch pins
// RULE12: configuration held until reset, then default
module iosm_top
    import iosm_pkg::*;
(
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    // configuration command from the host command decoder
    input  wire logic                      cfg_cmd_valid,
    input  wire logic [1:0]                cfg_cmd_sel,
    // internal functions
    input  wire iosm_pkg::iosm_func_out_s  func_out,
    output iosm_pkg::iosm_func_in_s        func_in_ff,
    output iosm_pkg::iosm_cfg_e            cfg_ff,
    // switch matrix pins
    input  wire logic [11:0]               pin_in,
    input  wire logic                      service_request_pin,
    output logic [11:0]                    pin_out_ff,
    output logic [11:0]                    pin_oe_ff
);
    import iosm_pkg::*;

    iosm_cfg_e      nxt_cfg;
    logic [11:0]    nxt_pin_out;
    logic [11:0]    nxt_pin_oe;
    iosm_func_in_s  nxt_func_in;

    ////////////////////////////////////////////////////////////////////////
    // configuration latch: first command after boot wins, later ones ignored

    always_comb
    begin
        nxt_cfg = cfg_ff;
        if (cfg_ff == IOSM_CFG_DEFAULT && cfg_cmd_valid)
        begin
            case (cfg_cmd_sel)                                     // [RULE9]
                IOSM_SEL_A: nxt_cfg = IOSM_CFG_A;
                IOSM_SEL_B: nxt_cfg = IOSM_CFG_B;
                IOSM_SEL_C: nxt_cfg = IOSM_CFG_C;
                IOSM_SEL_D: nxt_cfg = IOSM_CFG_D;
                default:    nxt_cfg = cfg_ff;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            cfg_ff <= IOSM_CFG_DEFAULT;                            // [RULE12]
        else
            cfg_ff <= nxt_cfg;                                     // [RULE12]
    end

    ////////////////////////////////////////////////////////////////////////
    // routing, registered so every pin comes from a flip-flop

    iosm_route u_route (
        .cfg                 (cfg_ff),
        .func_out            (func_out),
        .pin_in              (pin_in),
        .service_request_pin (service_request_pin),
        .pin_out             (nxt_pin_out),
        .pin_oe              (nxt_pin_oe),
        .func_in             (nxt_func_in)
    );

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_out_ff <= IOSM_OUT_RESET;
            pin_oe_ff  <= IOSM_OE_RESET;                           // [RULE1]
        end
        else
        begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff  <= nxt_pin_oe;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            func_in_ff <= '0;
        else
            func_in_ff <= nxt_func_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    reset_release_a: assert property (@(posedge clock) !rst_n |-> pin_oe_ff == 12'h000) // [RULE1]
        else $error("pins driven during reset");

    spi_fixed_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
        $past(rst_n) |-> pin_oe_ff[0] && pin_oe_ff[3] && pin_oe_ff[4] && !pin_oe_ff[1] && !pin_oe_ff[2])
        else $error("spi slave pins misrouted");

    pin5_drive_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
        $past(rst_n) |-> pin_oe_ff[5] == ($past(cfg_ff) == IOSM_CFG_C))
        else $error("pin five enable wrong");

    pin6_input_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
        $past(cfg_ff) == IOSM_CFG_D && $past(rst_n) |-> func_in_ff.uart_rx == $past(pin_in[6]))
        else $error("pin six not uart rx in D");

    pin7_source_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
        $past(rst_n) && ($past(cfg_ff) == IOSM_CFG_C || $past(cfg_ff) == IOSM_CFG_D)
        |-> pin_oe_ff[7] && pin_out_ff[7] == $past(func_out.uart_tx))
        else $error("pin seven not uart tx");

    pin8_source_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
        $past(rst_n) && $past(cfg_ff) == IOSM_CFG_B
        |-> pin_oe_ff[8] && pin_out_ff[8] == $past(func_out.front_end_receive_enable))
        else $error("pin eight not receive enable");

    pin9_source_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
        $past(rst_n) && $past(cfg_ff) == IOSM_CFG_A |-> !pin_oe_ff[9] && func_in_ff.uart_rx == $past(pin_in[9]))
        else $error("pin nine not uart rx in A");

    audio_clock_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
        $past(rst_n) |-> !pin_oe_ff[10] && !pin_oe_ff[11])
        else $error("audio clock pins driven");

    cfg_take_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
        cfg_ff == IOSM_CFG_DEFAULT && cfg_cmd_valid && cfg_cmd_sel == IOSM_SEL_B ##1 1'b1 |-> cfg_ff == IOSM_CFG_B)
        else $error("configuration command not applied");

    unconfigured_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
        $past(cfg_ff) == IOSM_CFG_DEFAULT |-> pin_oe_ff[11:5] == 7'h00)
        else $error("mux pins driven before configuration");

    cfg_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE12]
        cfg_ff != IOSM_CFG_DEFAULT |=> $stable(cfg_ff))
        else $error("configuration changed without reset");

    ////////////////////////////////////////////////////////////////////////
    // reset and fixed spi slave pins

    reset_outputs_a: assert property (@(posedge clock) !rst_n // [RULE1]
        |-> pin_out_ff == IOSM_OUT_RESET && func_in_ff == '0)
        else $error("outputs not cleared during reset");

    reset_cfg_a: assert property (@(posedge clock) !rst_n // [RULE12]
        |-> cfg_ff == IOSM_CFG_DEFAULT)
        else $error("configuration kept through reset");

    spi_source_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
        $past(rst_n)
        |-> pin_out_ff[0] == $past(func_out.spi_data_out)
            && pin_out_ff[3] == $past(func_out.slave_chip_select)
            && pin_out_ff[4] == $past(func_out.spi_interrupt))
        else $error("spi slave outputs not routed");

    spi_inputs_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
        $past(rst_n)
        |-> func_in_ff.spi_data_in == $past(pin_in[1])
            && func_in_ff.spi_clock == $past(pin_in[2])
            && func_in_ff.slave_service_request == $past(service_request_pin))
        else $error("spi slave inputs not routed");

    undriven_low_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
        (pin_out_ff & ~pin_oe_ff) == 12'h000)
        else $error("released pin carries a value");

    ////////////////////////////////////////////////////////////////////////
    // multiplexed pins, one source per configuration

    pin5_source_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
        $past(rst_n)
        |-> pin_out_ff[5] == ($past(cfg_ff) == IOSM_CFG_C && $past(func_out.audio_data_out)))
        else $error("pin five value wrong");

    pin6_released_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
        $past(rst_n) |-> !pin_oe_ff[6])
        else $error("pin six driven");

    audio_in_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
        $past(rst_n) && $past(cfg_ff) inside {IOSM_CFG_A, IOSM_CFG_B, IOSM_CFG_C}
        |-> func_in_ff.audio_data_in == $past(pin_in[6]))
        else $error("pin six not audio in");

    d_inputs_off_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4] [RULE8]
        $past(rst_n) && $past(cfg_ff) == IOSM_CFG_D
        |-> !func_in_ff.audio_data_in && !func_in_ff.audio_bit_clock && !func_in_ff.audio_word_select)
        else $error("audio inputs live in D");

    pin7_audio_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
        $past(rst_n) && $past(cfg_ff) inside {IOSM_CFG_A, IOSM_CFG_B}
        |-> pin_oe_ff[7] && pin_out_ff[7] == $past(func_out.audio_data_out))
        else $error("pin seven not audio out");

    pin8_uart_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6]
        $past(rst_n) && $past(cfg_ff) == IOSM_CFG_A
        |-> pin_oe_ff[8] && pin_out_ff[8] == $past(func_out.uart_tx))
        else $error("pin eight not uart tx in A");

    pin8_enable_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE6] [RULE11]
        $past(rst_n) && $past(cfg_ff) inside {IOSM_CFG_C, IOSM_CFG_D}
        |-> pin_oe_ff[8] && pin_out_ff[8] == $past(func_out.front_end_receive_enable))
        else $error("pin eight not receive enable");

    pin9_enable_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7] [RULE11]
        $past(rst_n) && $past(cfg_ff) inside {IOSM_CFG_B, IOSM_CFG_C, IOSM_CFG_D}
        |-> pin_oe_ff[9] && pin_out_ff[9] == $past(func_out.front_end_amplifier_enable))
        else $error("pin nine not amplifier enable");

    rx_unrouted_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE7]
        $past(rst_n) && $past(cfg_ff) inside {IOSM_CFG_B, IOSM_CFG_C}
        |-> !func_in_ff.uart_rx)
        else $error("uart rx live without a pin");

    audio_clock_in_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE8]
        $past(rst_n) && $past(cfg_ff) inside {IOSM_CFG_A, IOSM_CFG_B, IOSM_CFG_C}
        |-> func_in_ff.audio_bit_clock == $past(pin_in[10])
            && func_in_ff.audio_word_select == $past(pin_in[11]))
        else $error("audio clock inputs not routed");

    unconfigured_in_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
        $past(cfg_ff) == IOSM_CFG_DEFAULT
        |-> !func_in_ff.audio_data_in && !func_in_ff.audio_bit_clock
            && !func_in_ff.audio_word_select && !func_in_ff.uart_rx)
        else $error("mux inputs live before configuration");

    unconfigured_out_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
        $past(cfg_ff) == IOSM_CFG_DEFAULT |-> pin_out_ff[11:5] == 7'h00)
        else $error("mux outputs live before configuration");

    ////////////////////////////////////////////////////////////////////////
    // whole enable map per configuration

    oe_default_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE10]
        $past(rst_n) && $past(cfg_ff) == IOSM_CFG_DEFAULT |-> pin_oe_ff == 12'h019)
        else $error("enables wrong before configuration");

    oe_cfg_a_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
        $past(rst_n) && $past(cfg_ff) == IOSM_CFG_A |-> pin_oe_ff == 12'h199)
        else $error("enables wrong in configuration A");

    oe_cfg_b_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
        $past(rst_n) && $past(cfg_ff) == IOSM_CFG_B |-> pin_oe_ff == 12'h399)
        else $error("enables wrong in configuration B");

    oe_cfg_c_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
        $past(rst_n) && $past(cfg_ff) == IOSM_CFG_C |-> pin_oe_ff == 12'h3B9)
        else $error("enables wrong in configuration C");

    oe_cfg_d_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
        $past(rst_n) && $past(cfg_ff) == IOSM_CFG_D |-> pin_oe_ff == 12'h399)
        else $error("enables wrong in configuration D");

    ////////////////////////////////////////////////////////////////////////
    // configuration latch

    sel_a_take_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
        cfg_ff == IOSM_CFG_DEFAULT && cfg_cmd_valid && cfg_cmd_sel == IOSM_SEL_A
        |=> cfg_ff == IOSM_CFG_A)
        else $error("command A not applied");

    sel_c_take_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
        cfg_ff == IOSM_CFG_DEFAULT && cfg_cmd_valid && cfg_cmd_sel == IOSM_SEL_C
        |=> cfg_ff == IOSM_CFG_C)
        else $error("command C not applied");

    sel_d_take_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
        cfg_ff == IOSM_CFG_DEFAULT && cfg_cmd_valid && cfg_cmd_sel == IOSM_SEL_D
        |=> cfg_ff == IOSM_CFG_D)
        else $error("command D not applied");

    cfg_idle_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE12]
        cfg_ff == IOSM_CFG_DEFAULT && !cfg_cmd_valid
        |=> cfg_ff == IOSM_CFG_DEFAULT)
        else $error("configuration left default without command");

    cfg_legal_a: assert property (@(posedge clock) disable iff (!rst_n) // [RULE9]
        cfg_ff inside {IOSM_CFG_DEFAULT, IOSM_CFG_A, IOSM_CFG_B, IOSM_CFG_C, IOSM_CFG_D})
        else $error("configuration code out of range");

endmodule

// ### rtl/iosm_pkg.sv
// package for the io switch matrix: configuration codes and pin bundles
package iosm_pkg;

    // configuration selected by the host command
    typedef enum logic [2:0] {
        IOSM_CFG_DEFAULT = 3'h0,
        IOSM_CFG_A       = 3'h1,
        IOSM_CFG_B       = 3'h2,
        IOSM_CFG_C       = 3'h3,
        IOSM_CFG_D       = 3'h4
    } iosm_cfg_e;

    // code carried by the host command, two bits for A to D
    localparam logic [1:0] IOSM_SEL_A = 2'h0;
    localparam logic [1:0] IOSM_SEL_B = 2'h1;
    localparam logic [1:0] IOSM_SEL_C = 2'h2;
    localparam logic [1:0] IOSM_SEL_D = 2'h3;

    localparam int unsigned IOSM_NUM_PINS = 12;
    localparam int unsigned IOSM_FIRST_MUX = 5;
    localparam logic [11:0] IOSM_OE_RESET = 12'h000;
    localparam logic [11:0] IOSM_OUT_RESET = 12'h000;

    // internal functions driven towards the pins
    typedef struct packed {
        logic spi_data_out;
        logic slave_chip_select;
        logic spi_interrupt;
        logic audio_data_out;
        logic uart_tx;
        logic front_end_receive_enable;
        logic front_end_amplifier_enable;
    } iosm_func_out_s;

    // pin levels returned to internal functions
    typedef struct packed {
        logic spi_data_in;
        logic spi_clock;
        logic slave_service_request;
        logic audio_data_in;
        logic audio_bit_clock;
        logic audio_word_select;
        logic uart_rx;
    } iosm_func_in_s;

endpackage

// ### rtl/iosm_route.sv
// combinational routing table of the io switch matrix
module iosm_route
    import iosm_pkg::*;
(
    // selection and functions
    input  wire iosm_pkg::iosm_cfg_e       cfg,
    input  wire iosm_pkg::iosm_func_out_s  func_out,
    // pin side
    input  wire logic [11:0]               pin_in,
    input  wire logic                      service_request_pin,
    output logic [11:0]                    pin_out,
    output logic [11:0]                    pin_oe,
    output iosm_pkg::iosm_func_in_s        func_in
);
    import iosm_pkg::*;

    always_comb
    begin
        pin_out = IOSM_OUT_RESET;
        pin_oe  = IOSM_OE_RESET;
        func_in = '0;
        // fixed spi slave pins in every configuration
        pin_out[0] = func_out.spi_data_out;                        // [RULE2]
        pin_oe[0]  = 1'b1;
        pin_out[3] = func_out.slave_chip_select;
        pin_oe[3]  = 1'b1;
        pin_out[4] = func_out.spi_interrupt;
        pin_oe[4]  = 1'b1;
        func_in.spi_data_in           = pin_in[1];
        func_in.spi_clock             = pin_in[2];
        func_in.slave_service_request = service_request_pin;
        case (cfg)
            IOSM_CFG_A:
            begin
                func_in.audio_data_in   = pin_in[6];               // [RULE4]
                pin_out[7] = func_out.audio_data_out;              // [RULE5]
                pin_oe[7]  = 1'b1;
                pin_out[8] = func_out.uart_tx;                     // [RULE6]
                pin_oe[8]  = 1'b1;
                func_in.uart_rx         = pin_in[9];               // [RULE7]
                func_in.audio_bit_clock   = pin_in[10];            // [RULE8]
                func_in.audio_word_select = pin_in[11];
            end
            IOSM_CFG_B, IOSM_CFG_C:
            begin
                func_in.audio_data_in = pin_in[6];                 // [RULE4]
                if (cfg == IOSM_CFG_C)
                begin
                    pin_out[5] = func_out.audio_data_out;          // [RULE3]
                    pin_oe[5]  = 1'b1;
                    pin_out[7] = func_out.uart_tx;                 // [RULE5]
                end
                else
                begin
                    pin_out[7] = func_out.audio_data_out;          // [RULE5]
                end
                pin_oe[7]  = 1'b1;
                pin_out[8] = func_out.front_end_receive_enable;    // [RULE6] [RULE11]
                pin_oe[8]  = 1'b1;
                pin_out[9] = func_out.front_end_amplifier_enable;  // [RULE7] [RULE11]
                pin_oe[9]  = 1'b1;
                func_in.audio_bit_clock   = pin_in[10];            // [RULE8]
                func_in.audio_word_select = pin_in[11];
            end
            IOSM_CFG_D:
            begin
                func_in.uart_rx = pin_in[6];                       // [RULE4]
                pin_out[7] = func_out.uart_tx;                     // [RULE5]
                pin_oe[7]  = 1'b1;
                pin_out[8] = func_out.front_end_receive_enable;    // [RULE6] [RULE11]
                pin_oe[8]  = 1'b1;
                pin_out[9] = func_out.front_end_amplifier_enable;  // [RULE7] [RULE11]
                pin_oe[9]  = 1'b1;
            end
            default:
            begin
                // pins 5 to 11 stay released until configured
                pin_oe[11:5] = 7'h00;                              // [RULE10]
            end
        endcase
    end

endmodule

// ### sim/iosm_host_model.sv
// far-side model: host controller and rf front end on the switch pins
module iosm_host_model
    import iosm_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // device pin drivers
    input  wire logic [11:0] pin_out,
    input  wire logic [11:0] pin_oe,
    // levels the host wants on its pins
    input  wire logic [11:0] host_lvl,
    input  wire logic        srq_lvl,
    // resolved pin levels
    output logic [11:0]      pin_in,
    output logic             service_request_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // pins the host side drives: spi data/clock, audio in, uart rx, audio clock/select
    localparam logic [11:0] HOST_PINS = 12'h0E46;

    logic [11:0] float_ff;

    ////////////////////////////////////////////////////////////
    // released pins must not look like held values, so they wobble
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            float_ff <= 12'h000;
        else
            float_ff <= ~float_ff;
    end

    // device drive wins; front-end enables only arrive through these pins
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((HOST_PINS & host_lvl) | (~HOST_PINS & float_ff)));
    assign service_request_pin = srq_lvl;
endmodule

// ### sim/testbench.sv
// self-checking bench for the io switch matrix
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import iosm_pkg::*;

    logic           clock;
    logic           rst_n;
    logic           cfg_cmd_valid;
    logic [1:0]     cfg_cmd_sel;
    iosm_func_out_s func_out;
    iosm_func_in_s  func_in_ff;
    iosm_cfg_e      cfg_ff;
    logic [11:0]    pin_in;
    logic           service_request_pin;
    logic [11:0]    pin_out_ff;
    logic [11:0]    pin_oe_ff;
    logic [11:0]    host_lvl;
    logic           srq_lvl;
    int             bad_count;
    int             checked;

    iosm_top i_iosm_top (.clock(clock), .rst_n(rst_n), .cfg_cmd_valid(cfg_cmd_valid),
        .cfg_cmd_sel(cfg_cmd_sel), .func_out(func_out), .func_in_ff(func_in_ff), .cfg_ff(cfg_ff),
        .pin_in(pin_in), .service_request_pin(service_request_pin), .pin_out_ff(pin_out_ff),
        .pin_oe_ff(pin_oe_ff));

    iosm_host_model i_iosm_host_model (.clock(clock), .rst_n(rst_n), .pin_out(pin_out_ff),
        .pin_oe(pin_oe_ff), .host_lvl(host_lvl), .srq_lvl(srq_lvl), .pin_in(pin_in),
        .service_request_pin(service_request_pin));

    always #25 clock = ~clock;

    ////////////////////////////////////////////////////////////
    // c: 0 default, 1..4 configurations A..D
    function automatic logic [11:0] exp_out(int c, iosm_func_out_s f);
        logic [11:0] v;
        v = {7'h00, f.spi_interrupt, f.slave_chip_select, 2'h0, f.spi_data_out};
        if (c != 0)
        begin
            v[5] = (c == 3) & f.audio_data_out;
            v[7] = (c < 3) ? f.audio_data_out : f.uart_tx;
            v[8] = (c == 1) ? f.uart_tx : f.front_end_receive_enable;
            v[9] = (c != 1) & f.front_end_amplifier_enable;
        end
        return v;
    endfunction

    function automatic logic [6:0] exp_in(int c, logic [11:0] h, logic s);
        logic a;
        a = (c >= 1) & (c <= 3);
        return {h[1], h[2], s, a & h[6], a & h[10], a & h[11], (c == 1) ? h[9] : (c == 4) & h[6]};
    endfunction

    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    task automatic cmp_vec(logic [11:0] got, logic [11:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: pins got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_cfg(iosm_cfg_e got, iosm_cfg_e exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t: configuration got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // a stray command during reset must not leak through
    // strobe drops a cycle early so a command may follow release directly
    task automatic apply_reset();
        rst_n = 1'b0;
        cfg_cmd_valid = 1'b1;
        tick(9);
        cfg_cmd_valid = 1'b0;
        tick(1);
        cmp_vec(pin_oe_ff | pin_out_ff, 12'h000);
        cmp_cfg(cfg_ff, IOSM_CFG_DEFAULT);
        rst_n = 1'b1;
    endtask

    // one-hot walk of every function, then all high, then two host patterns
    task automatic check_routes(int c);
        for (int i = 0; i < 8; i++)
        begin
            func_out = (i == 7) ? 7'h7F : 7'h01 << i;
            tick(2);
            cmp_vec(pin_out_ff, exp_out(c, func_out));
            cmp_vec(pin_oe_ff, exp_out(c, 7'h7F));
        end
        for (int i = 0; i < 2; i++)
        begin
            host_lvl = i ? 12'h0E46 : 12'h0204;
            srq_lvl = i[0];
            tick(2);
            cmp_vec({5'h00, func_in_ff}, {5'h00, exp_in(c, host_lvl, srq_lvl)});
        end
    endtask

    task automatic send_cmd(logic [1:0] sel);
        cfg_cmd_sel = sel;
        cfg_cmd_valid = 1'b1;
        tick(1);
        cfg_cmd_valid = 1'b0;
    endtask

    task automatic run_cfg(logic [1:0] sel, iosm_cfg_e exp);
        apply_reset();
        send_cmd(sel);
        cmp_cfg(cfg_ff, exp);
        check_routes(int'(exp));
        send_cmd(~sel);
        tick(1);
        cmp_cfg(cfg_ff, exp);
        check_routes(int'(exp));
    endtask

    // mid-run reset after a locked configuration falls back to default
    task automatic run_default();
        apply_reset();
        check_routes(0);
        cmp_cfg(cfg_ff, IOSM_CFG_DEFAULT);
    endtask

    initial
    begin
        clock = 1'b0;
        bad_count = 0;
        checked = 0;
        func_out = 7'h00;
        host_lvl = 12'h0000;
        srq_lvl = 1'b0;
        cfg_cmd_sel = 2'h0;
        rst_n = 1'b0;
        cfg_cmd_valid = 1'b0;
        #2;
        run_cfg(IOSM_SEL_A, IOSM_CFG_A);
        run_cfg(IOSM_SEL_B, IOSM_CFG_B);
        run_cfg(IOSM_SEL_C, IOSM_CFG_C);
        run_cfg(IOSM_SEL_D, IOSM_CFG_D);
        run_default();
        end_sim();
    end
endmodule
